// ---- urxs_pkg.sv ----
// Package: constants and types for the receive status and character block
// =====================================================================
// Functional notes
// - Full flag when queue holds maximum characters
// - Half flag at four or fewer slots free
// - Data-ready flag while queue not empty
// - Character bits meaningful only when data ready
// - Stale flag after over 30 bit times
// - Stale clears on character read, low when empty
// - Arrival when full overwrites, sets overrun
// - Framing fault on missing stop bit
// - Break when data and stop bits zero, parity bit too when enabled
// - Break also sets framing, parity if odd
// - Parity fault when check bit mismatches
// - Parity fault reads zero when parity disabled
// - Low byte shows oldest unread character
// - Seven-bit mode forces character bit seven zero
// - Maskable interrupt per queue status condition
// - Enable, then read once before enabling interrupts
package urxs_pkg;

   // =====================================================================
   // Timing
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          BAUD_DEFAULT    = 115_200;
   localparam logic [15:0] DIV_RST         = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [4:0]  STALE_BIT_TIMES = 5'h1e;

   // =====================================================================
   // Queue geometry
   localparam int          FIFO_DEPTH = 16;
   localparam logic [4:0]  FULL_LEVEL = 5'h10;
   localparam logic [4:0]  HALF_LEVEL = 5'h0c;

   // =====================================================================
   // Register offsets
   localparam logic [7:0]  ADDR_RX       = 8'h00;
   localparam logic [7:0]  ADDR_CTRL     = 8'h04;
   localparam logic [7:0]  ADDR_DIV      = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_ST   = 8'h0c;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;

   // =====================================================================
   // Field positions
   localparam int BIT_FULL  = 15;
   localparam int BIT_HALF  = 14;
   localparam int BIT_READY = 13;
   localparam int BIT_STALE = 12;
   localparam int BIT_OVR   = 11;
   localparam int BIT_FERR  = 10;
   localparam int BIT_BRK   = 9;
   localparam int BIT_PERR  = 8;
   localparam int IRQ_FULL  = 3;
   localparam int IRQ_HALF  = 2;
   localparam int IRQ_READY = 1;
   localparam int IRQ_STALE = 0;

   // =====================================================================
   // Reset values
   localparam logic [4:0]  CTRL_RST = 5'h00;
   localparam logic [3:0]  MASK_RST = 4'h0;

   // =====================================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP   = 3'b100
   } urxs_state_t;

   typedef struct packed {
      logic       seven_bit;
      logic       parity_odd;
      logic       parity_en;
      logic       receiver_enable_bit;
      logic       port_enable_bit;
   } urxs_ctrl_t;

   typedef struct packed {
      logic       rx_overwrite_flag;
      logic       ferr;
      logic       brk;
      logic       perr;
      logic [7:0] data;
   } urxs_entry_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } urxs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } urxs_apb_rsp_t;

endpackage : urxs_pkg

// ---- urxs_rx_status_char.sv ----
// Serial receiver with character queue, status register and APB slave
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module urxs_rx_status_char
   import urxs_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   // Register bus
   input  wire urxs_apb_req_t apb_req,
   output urxs_apb_rsp_t      apb_rsp,
   // Serial line and interrupt
   input  wire logic          rx_pin,
   output logic               irq
);

   // =====================================================================
   // State
   typedef struct packed {
      logic [2:0]                    sync;
      logic                          line;
      logic                          armed;
      urxs_state_t                   state;
      logic [15:0]                   baud_cnt;
      logic [2:0]                    bit_idx;
      logic [7:0]                    shreg;
      logic                          par_bit;
      urxs_entry_t [FIFO_DEPTH-1:0]  mem;
      logic [3:0]                    wr_ptr;
      logic [3:0]                    rd_ptr;
      logic [4:0]                    count;
      logic [15:0]                   age_div;
      logic [4:0]                    age_cnt;
      urxs_ctrl_t                    ctrl;
      logic [15:0]                   div;
      logic [3:0]                    irq_st;
      logic [3:0]                    irq_mask;
      logic [31:0]                   prdata;
   } urxs_regs_t;

   urxs_regs_t  st_r;
   urxs_regs_t  st_nxt;

   logic        setup;
   logic        access;
   logic        mapped;
   logic        rx_on;
   logic        rx_done;
   logic        pop;
   logic        full;
   logic        half;
   logic        ready;
   logic        stale;
   logic        data_par;
   logic [7:0]  rx_data;
   urxs_entry_t rx_ent;
   urxs_entry_t head;
   logic [3:0]  cond;
   logic [31:0] rd_word;

   // =====================================================================
   // Bus decode
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign mapped = (apb_req.paddr == ADDR_RX) | (apb_req.paddr == ADDR_CTRL) |
                   (apb_req.paddr == ADDR_DIV) | (apb_req.paddr == ADDR_IRQ_ST) |
                   (apb_req.paddr == ADDR_IRQ_MASK);

   // Zero wait states; every access completes in its first access cycle
   assign apb_rsp = '{prdata:  st_r.prdata,
                      pready:  1'b1,
                      pslverr: access & ~mapped};

   // =====================================================================
   // Queue status
   assign full  = (st_r.count == FULL_LEVEL);
   assign half  = (st_r.count >= HALF_LEVEL);
   assign ready = (st_r.count != 5'h00);
   assign stale = ready & (st_r.age_cnt > STALE_BIT_TIMES);
   assign head  = st_r.mem[st_r.rd_ptr];
   // Pop only what the setup-cycle word reported, so no unseen character is lost
   assign pop   = access & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX) & st_r.prdata[BIT_READY];
   assign cond  = {full, half, ready, stale};
   assign irq   = |(st_r.irq_st & st_r.irq_mask);

   // =====================================================================
   // Character decode at the stop-bit sample
   assign rx_on    = st_r.ctrl.port_enable_bit & st_r.ctrl.receiver_enable_bit;
   assign rx_done  = (st_r.state == ST_STOP) & (st_r.baud_cnt == 16'h0000);
   // Seven-bit characters land one place high in the shifter
   assign rx_data  = st_r.ctrl.seven_bit ? {1'b0, st_r.shreg[7:1]} : st_r.shreg;
   assign data_par = ^rx_data;

   always_comb begin
      rx_ent                   = '0;
      rx_ent.data              = rx_data;
      rx_ent.ferr              = ~st_r.line;
      rx_ent.brk               = (rx_data == 8'h00) & ~st_r.line & ~st_r.par_bit;
      rx_ent.perr              = st_r.ctrl.parity_en &
                                 (st_r.par_bit != (data_par ^ st_r.ctrl.parity_odd));
      if (rx_ent.brk) begin
         rx_ent.ferr = 1'b1;
         rx_ent.perr = rx_ent.perr | (st_r.ctrl.parity_en & st_r.ctrl.parity_odd);
      end
      rx_ent.rx_overwrite_flag = full & ~pop;
   end

   // =====================================================================
   // Read mux; character status shown only with a character present
   always_comb begin
      rd_word = 32'h0000_0000;
      case (apb_req.paddr)
         ADDR_RX: begin
            rd_word[BIT_FULL]  = full;
            rd_word[BIT_HALF]  = half;
            rd_word[BIT_READY] = ready;
            rd_word[BIT_STALE] = stale;
            if (ready) begin
               rd_word[BIT_OVR]  = head.rx_overwrite_flag;
               rd_word[BIT_FERR] = head.ferr;
               rd_word[BIT_BRK]  = head.brk;
               rd_word[BIT_PERR] = head.perr & st_r.ctrl.parity_en;
               rd_word[7:0]      = st_r.ctrl.seven_bit ? {1'b0, head.data[6:0]} : head.data;
            end
         end
         ADDR_CTRL:     rd_word[4:0]  = st_r.ctrl;
         ADDR_DIV:      rd_word[15:0] = st_r.div;
         ADDR_IRQ_ST:   rd_word[3:0]  = st_r.irq_st;
         ADDR_IRQ_MASK: rd_word[3:0]  = st_r.irq_mask;
         default:       rd_word       = 32'h0000_0000;
      endcase
   end

   // =====================================================================
   // Next state
   always_comb begin
      st_nxt      = st_r;

      // Line synchroniser; a level counts once the last two stages agree
      st_nxt.sync = {st_r.sync[1:0], rx_pin};
      if (st_r.sync[2] == st_r.sync[1]) begin
         st_nxt.line = st_r.sync[2];
      end

      // Register writes
      if (access & apb_req.pwrite) begin
         case (apb_req.paddr)
            ADDR_CTRL:     st_nxt.ctrl     = urxs_ctrl_t'(apb_req.pwdata[4:0]);
            ADDR_DIV:      st_nxt.div      = apb_req.pwdata[15:0];
            ADDR_IRQ_MASK: st_nxt.irq_mask = apb_req.pwdata[3:0];
            default:       st_nxt.div      = st_r.div;
         endcase
      end

      // Read data captured in the setup cycle, stable through access
      if (setup & ~apb_req.pwrite) begin
         st_nxt.prdata = rd_word;
      end

      // Sticky status; a condition still present wins over the clear
      if (access & apb_req.pwrite & (apb_req.paddr == ADDR_IRQ_ST)) begin
         st_nxt.irq_st = st_r.irq_st & ~apb_req.pwdata[3:0];
      end
      st_nxt.irq_st = st_nxt.irq_st | cond;

      // Receiver sequencer
      if (st_r.baud_cnt != 16'h0000) begin
         st_nxt.baud_cnt = st_r.baud_cnt - 16'h0001;
      end
      case (st_r.state)
         ST_IDLE: begin
            // A break holds the line low; wait for idle high before rearming
            if (st_r.line) begin
               st_nxt.armed = 1'b1;
            end
            if (rx_on & st_r.armed & ~st_r.line) begin
               st_nxt.state    = ST_START;
               st_nxt.baud_cnt = {1'b0, st_r.div[15:1]};
               st_nxt.armed    = 1'b0;
            end
         end
         ST_START: begin
            if (st_r.baud_cnt == 16'h0000) begin
               st_nxt.baud_cnt = st_r.div - 16'h0001;
               st_nxt.bit_idx  = 3'h0;
               st_nxt.state    = st_r.line ? ST_IDLE : ST_DATA;
            end
         end
         ST_DATA: begin
            if (st_r.baud_cnt == 16'h0000) begin
               st_nxt.baud_cnt = st_r.div - 16'h0001;
               st_nxt.shreg    = {st_r.line, st_r.shreg[7:1]};
               st_nxt.bit_idx  = st_r.bit_idx + 3'h1;
               if (st_r.bit_idx == (st_r.ctrl.seven_bit ? 3'h6 : 3'h7)) begin
                  if (st_r.ctrl.seven_bit) begin
                     st_nxt.shreg = {st_r.line, st_r.shreg[7:1]};
                  end
                  st_nxt.par_bit = 1'b0;
                  st_nxt.state   = st_r.ctrl.parity_en ? ST_PARITY : ST_STOP;
               end
            end
         end
         ST_PARITY: begin
            if (st_r.baud_cnt == 16'h0000) begin
               st_nxt.baud_cnt = st_r.div - 16'h0001;
               st_nxt.par_bit  = st_r.line;
               st_nxt.state    = ST_STOP;
            end
         end
         ST_STOP: begin
            if (st_r.baud_cnt == 16'h0000) begin
               st_nxt.state = ST_IDLE;
            end
         end
         default: st_nxt.state = ST_IDLE;
      endcase

      // Queue update; when full the newest entry is overwritten in place
      if (rx_done & full & ~pop) begin
         st_nxt.mem[st_r.wr_ptr - 4'h1] = rx_ent;
      end else if (rx_done) begin
         st_nxt.mem[st_r.wr_ptr] = rx_ent;
         st_nxt.wr_ptr           = st_r.wr_ptr + 4'h1;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 4'h1;
      end
      if (rx_done & ~full & ~pop) begin
         st_nxt.count = st_r.count + 5'h01;
      end else if (pop & ~rx_done) begin
         st_nxt.count = st_r.count - 5'h01;
      end

      // Age of unread data, counted in bit times, saturating
      if (~ready | pop) begin
         st_nxt.age_div = st_r.div;
         st_nxt.age_cnt = 5'h00;
      end else if (st_r.age_div <= 16'h0001) begin
         st_nxt.age_div = st_r.div;
         if (st_r.age_cnt != 5'h1f) begin
            st_nxt.age_cnt = st_r.age_cnt + 5'h01;
         end
      end else begin
         st_nxt.age_div = st_r.age_div - 16'h0001;
      end
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r          <= '0;
         st_r.sync     <= 3'h7;
         st_r.line     <= 1'b1;
         st_r.state    <= ST_IDLE;
         st_r.ctrl     <= urxs_ctrl_t'(CTRL_RST);
         st_r.div      <= DIV_RST;
         st_r.age_div  <= DIV_RST;
         st_r.irq_mask <= MASK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // Assertions
   property p_full_read;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX)) |=>
         (apb_rsp.prdata[BIT_FULL] == $past(st_r.count == FULL_LEVEL));
   endproperty
   a_full_read: assert property (p_full_read) else $error("full flag wrong");

   property p_half_read;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX)) |=>
         (apb_rsp.prdata[BIT_HALF] == ($past(st_r.count) >= HALF_LEVEL));
   endproperty
   a_half_read: assert property (p_half_read) else $error("half flag wrong");

   property p_ready_irq;
      @(posedge clk_sys) disable iff (!nrst)
      (st_r.count != 5'h00) |=> st_r.irq_st[IRQ_READY];
   endproperty
   a_ready_irq: assert property (p_ready_irq) else $error("ready event lost");

   property p_stale_set;
      @(posedge clk_sys) disable iff (!nrst)
      (ready & ~pop & (st_r.age_cnt == STALE_BIT_TIMES) & (st_r.age_div <= 16'h0001)) |=> stale;
   endproperty
   a_stale_set: assert property (p_stale_set) else $error("stale flag late");

   property p_stale_clear;
      @(posedge clk_sys) disable iff (!nrst)
      pop |=> (~stale [*8]);
   endproperty
   a_stale_clear: assert property (p_stale_clear) else $error("stale not cleared");

   property p_overrun;
      @(posedge clk_sys) disable iff (!nrst)
      (rx_done & full & ~pop) |=>
         ((st_r.count == FULL_LEVEL) && st_r.mem[st_r.wr_ptr - 4'h1].rx_overwrite_flag);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not marked");

   property p_break_frame;
      @(posedge clk_sys) disable iff (!nrst)
      (rx_done & ~full & (rx_data == 8'h00) & ~st_r.line & ~st_r.par_bit) |=>
         (st_r.mem[$past(st_r.wr_ptr)].ferr &
          (st_r.mem[$past(st_r.wr_ptr)].perr | ~$past(st_r.ctrl.parity_odd) | ~$past(st_r.ctrl.parity_en)));
   endproperty
   a_break_frame: assert property (p_break_frame) else $error("break without fault");

   property p_parity_off;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX) & ~st_r.ctrl.parity_en) |=>
         ~apb_rsp.prdata[BIT_PERR];
   endproperty
   a_parity_off: assert property (p_parity_off) else $error("parity flag while off");

   property p_seven_bit;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX) & st_r.ctrl.seven_bit) |=>
         ~apb_rsp.prdata[7];
   endproperty
   a_seven_bit: assert property (p_seven_bit) else $error("bit seven not forced");

   property p_pop_count;
      @(posedge clk_sys) disable iff (!nrst)
      (pop & ~rx_done) |=> (st_r.count == $past(st_r.count) - 5'h01);
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("read did not pop");

   property p_ready_read;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX)) |=>
         (apb_rsp.prdata[BIT_READY] == ($past(st_r.count) != 5'h00));
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("ready flag wrong");

   property p_empty_read;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX) & (st_r.count == 5'h00)) |=>
         (apb_rsp.prdata[11:0] == 12'h000);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("character bits shown while empty");

   property p_head_read;
      @(posedge clk_sys) disable iff (!nrst)
      (setup & ~apb_req.pwrite & (apb_req.paddr == ADDR_RX) & ready & ~st_r.ctrl.seven_bit) |=>
         (apb_rsp.prdata[7:0] == st_r.mem[st_r.rd_ptr].data);
   endproperty
   a_head_read: assert property (p_head_read) else $error("head character wrong");

   property p_frame_push;
      @(posedge clk_sys) disable iff (!nrst)
      (rx_done & ~full) |=> (st_r.mem[$past(st_r.wr_ptr)].ferr == !$past(st_r.line));
   endproperty
   a_frame_push: assert property (p_frame_push) else $error("framing flag not stored");

   property p_break_push;
      @(posedge clk_sys) disable iff (!nrst)
      (rx_done & ~full) |=>
         (st_r.mem[$past(st_r.wr_ptr)].brk ==
          (($past(rx_data) == 8'h00) & !$past(st_r.line) & !$past(st_r.par_bit)));
   endproperty
   a_break_push: assert property (p_break_push) else $error("break mark not stored");

   property p_full_irq;
      @(posedge clk_sys) disable iff (!nrst)
      full |=> (st_r.irq_st[IRQ_FULL] & st_r.irq_st[IRQ_HALF]);
   endproperty
   a_full_irq: assert property (p_full_irq) else $error("full event lost");

   property p_age_empty;
      @(posedge clk_sys) disable iff (!nrst)
      ~ready |=> (st_r.age_cnt == 5'h00);
   endproperty
   a_age_empty: assert property (p_age_empty) else $error("age kept while empty");

endmodule : urxs_rx_status_char

// ---- urxs_line_tx.sv ----
// Behavioural model of the remote serial transmitter driving the receive line
`timescale 1ns/100ps
module urxs_line_tx
   import urxs_pkg::*;
#(
   parameter int BIT_CYC = 8
) (
   // Clock
   input  wire logic clk_sys,
   // Serial line
   output logic      rx_pin
);

   // =====================================================================
   // Line driver
   // Idle level is high, so the line rests there between frames
   initial rx_pin = 1'b1;

   task automatic hold_bit(input logic b);
      rx_pin <= b;
      repeat (BIT_CYC) @(posedge clk_sys);
   endtask : hold_bit

   // Bad parity or a low stop bit only when the caller asks for it
   task automatic send(input logic [7:0] d, input int nb, input logic par_en, input logic par_bit,
                       input logic stop_bit);
      @(posedge clk_sys);
      hold_bit(1'b0);
      for (int i = 0; i < nb; i++) begin
         hold_bit(d[i]);
      end
      if (par_en) begin
         hold_bit(par_bit);
      end
      hold_bit(stop_bit);
      // Two idle bits so the receiver sees the line high before the next start
      hold_bit(1'b1);
      hold_bit(1'b1);
   endtask : send

endmodule : urxs_line_tx

// ---- urxs_rx_status_char_tb_top.sv ----
// Self-checking testbench for the receive status and character block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module urxs_rx_status_char_tb_top
   import urxs_pkg::*;
;
   // =====================================================================
   // Signals
   localparam int BIT_CYC = 8;
   logic          clk_sys;
   logic          nrst;
   urxs_apb_req_t apb_req;
   urxs_apb_rsp_t apb_rsp;
   logic          rx_pin;
   logic          irq;
   int            mismatches;
   int            checks_done;
   logic [31:0]   rd_data;
   logic          rd_err;

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   urxs_rx_status_char dut_u (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .apb_req (apb_req),
      .apb_rsp (apb_rsp),
      .rx_pin  (rx_pin),
      .irq     (irq)
   );

   urxs_line_tx #(.BIT_CYC(BIT_CYC)) tx_u (
      .clk_sys (clk_sys),
      .rx_pin  (rx_pin)
   );

   // =====================================================================
   // Bus tasks
   // Waits for pready without a limit of its own; the watchdog ends a hang
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (apb_rsp.pready !== 1'b1);
      rd_data = apb_rsp.prdata;
      rd_err  = apb_rsp.pslverr;
      apb_req <= '0;
   endtask : apb_xfer

   task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp, input string nm);
      apb_xfer(1'b0, addr, 32'h0);
      `CHK(nm, exp, rd_data)
   endtask : chk_rd

   // Whole 32-bit word read, so status and character arrive together
   task automatic char_case(input logic [4:0] ctrl, input logic [7:0] d, input int nb, input logic pbit,
                            input logic stop, input logic [15:0] exp);
      apb_xfer(1'b1, ADDR_CTRL, {27'h0, ctrl});
      tx_u.send(d, nb, ctrl[2], pbit, stop);
      chk_rd(ADDR_RX, {16'h0, exp}, "char word");
      chk_rd(ADDR_RX, 32'h0, "empty after pop");
   endtask : char_case

   task automatic tally_and_finish();
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // =====================================================================
   // Tests
   initial begin
      nrst = 1'b0;
      apb_req = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      chk_rd(ADDR_CTRL, 32'h0, "ctrl reset");
      chk_rd(ADDR_DIV, {16'h0, DIV_RST}, "divisor reset");
      chk_rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
      apb_xfer(1'b1, ADDR_DIV, 32'(BIT_CYC));
      apb_xfer(1'b1, ADDR_CTRL, 32'h3);
      chk_rd(ADDR_RX, 32'h0, "init read");
      apb_xfer(1'b1, ADDR_RX, 32'hffff);
      chk_rd(ADDR_CTRL, 32'h3, "ctrl after ro write");
      apb_xfer(1'b0, 8'h14, 32'h0);
      `CHK("unmapped error", 1'b1, rd_err)
      `CHK("unmapped data", 32'h0, rd_data)
      // Character status cases, parity bit sent only when enabled
      char_case(5'h03, 8'ha5, 8, 1'b0, 1'b1, 16'h20a5);
      char_case(5'h07, 8'h31, 8, 1'b0, 1'b1, 16'h2131);
      char_case(5'h0f, 8'h31, 8, 1'b0, 1'b1, 16'h2031);
      char_case(5'h03, 8'h5a, 8, 1'b0, 1'b0, 16'h245a);
      char_case(5'h0f, 8'h00, 8, 1'b0, 1'b0, 16'h2700);
      char_case(5'h03, 8'h00, 8, 1'b0, 1'b0, 16'h2600);
      char_case(5'h13, 8'h7f, 7, 1'b0, 1'b1, 16'h207f);
      char_case(5'h03, 8'hff, 8, 1'b0, 1'b1, 16'h20ff);
      // Data left unread past the age limit
      tx_u.send(8'h3c, 8, 1'b0, 1'b0, 1'b1);
      repeat (32 * BIT_CYC) @(posedge clk_sys);
      chk_rd(ADDR_RX, 32'h303c, "stale word");
      chk_rd(ADDR_RX, 32'h0, "stale cleared");
      // Fill to full, then one more arrival overwrites the newest entry
      apb_xfer(1'b1, ADDR_IRQ_ST, 32'hf);
      for (int i = 0; i < 16; i++) begin
         tx_u.send(8'h80 + 8'(i), 8, 1'b0, 1'b0, 1'b1);
      end
      tx_u.send(8'hee, 8, 1'b0, 1'b0, 1'b1);
      chk_rd(ADDR_IRQ_ST, 32'hf, "irq status");
      `CHK("irq masked", 1'b0, irq)
      apb_xfer(1'b1, ADDR_IRQ_MASK, 32'h8);
      @(posedge clk_sys);
      `CHK("irq unmasked", 1'b1, irq)
      for (int k = 0; k < 16; k++) begin
         chk_rd(ADDR_RX, {16'h0, k == 0, k <= 4, 1'b1, k == 0, k == 15, 3'b0,
                k == 15 ? 8'hee : 8'h80 + 8'(k)}, "queue word");
      end
      chk_rd(ADDR_RX, 32'h0, "drained");
      apb_xfer(1'b1, ADDR_IRQ_ST, 32'hf);
      chk_rd(ADDR_IRQ_ST, 32'h0, "irq cleared");
      `CHK("irq low", 1'b0, irq)
      tally_and_finish();
   end

   // =====================================================================
   // Watchdog, well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish();
   end

endmodule : urxs_rx_status_char_tb_top
